// ===== src/swf_pkg.sv
// Shared constants, types and helpers of the sample word formatter
package swf_pkg;
  localparam int          SWF_ADC_W       = 16;
  localparam int          SWF_NCH         = 8;
  localparam int          SWF_MOD_CH      = 4;
  localparam int          SWF_DIG_PER_CH  = 4;
  localparam int          SWF_REPL_W      = 32;
  localparam int          SWF_FIFO_DEPTH  = 8;
  localparam int          SWF_AXI_ADDR_W  = 14;
  localparam int          SWF_IDX_W       = 12;
  // Register indices; byte address is four times the index
  localparam logic [11:0] SWF_CTRL_IDX    = 12'h000;
  localparam logic [11:0] SWF_STAT_IDX    = 12'h001;
  localparam logic [11:0] SWF_FSCODE_IDX  = 12'h466;
  // Control fields
  localparam int          SWF_EN_LSB      = 0;
  localparam int          SWF_MODE_LSB    = 8;
  localparam int          SWF_RCH_LSB     = 12;
  localparam int          SWF_GRP_BIT     = 15;
  localparam logic [31:0] SWF_CTRL_RST    = 32'h0000_0001;
  // Status fields
  localparam int          SWF_OVR_BIT     = 0;
  localparam int          SWF_BUSY_BIT    = 1;
  localparam int          SWF_DROP_BIT    = 2;
  // Packing shifts for the reduced resolution modes
  localparam int          SWF_FOUR_SHIFT  = 4;
  localparam int          SWF_TWO_SHIFT   = 2;
  localparam logic [31:0] SWF_FS_DEFAULT  = 32'h0000_8000;
  localparam logic [1:0]  SWF_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  SWF_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    digital_capture_off,
    four_digital_bits_in_word,
    two_digital_bits_in_word,
    digital_replaces_channel
  } swf_mode_e;

  typedef logic [SWF_ADC_W-1:0] swf_word_t;

  function automatic logic [11:0] swf_idx(input logic [SWF_AXI_ADDR_W-1:0] a);
    swf_idx = a[SWF_AXI_ADDR_W-1:2];
  endfunction
endpackage

// ===== src/swf_if.sv
// Internal carriers: register access port and valid/ready word stream
`timescale 1ns/1ps
interface swf_reg_if;
  logic        wr_en;
  logic [11:0] wr_idx;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic        wr_ok;
  logic [11:0] rd_idx;
  logic [31:0] rd_data;
  logic        rd_ok;
  modport bus  (output wr_en, wr_idx, wr_data, wr_strb, rd_idx, input wr_ok, rd_data, rd_ok);
  modport regs (input wr_en, wr_idx, wr_data, wr_strb, rd_idx, output wr_ok, rd_data, rd_ok);
endinterface

interface swf_stream_if #(parameter int W = 16);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, data, input ready);
  modport snk (input valid, data, output ready);
endinterface

// ===== src/swf_fifo.sv
// Word FIFO with valid/ready on both sides
`timescale 1ns/1ps
module swf_fifo #(
  parameter int W     = 16,
  parameter int DEPTH = 8
) (
  input  wire logic  i_mclk,  // Clock
  input  wire logic  i_nrst,  // Async reset, active low
  swf_stream_if.snk  wr,      // Filling side
  swf_stream_if.src  rd       // Draining side
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0]   cnt_q;
  logic          push;
  logic          pop;

  assign wr.ready = (cnt_q != (AW+1)'(DEPTH));
  assign rd.valid = (cnt_q != '0);
  assign rd.data  = mem[rp_q];
  assign push     = wr.valid & wr.ready;
  assign pop      = rd.valid & rd.ready;

  always_ff @(posedge i_mclk) begin
    if (push) begin
      mem[wp_q] <= wr.data;
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wp_q <= (wp_q == AW'(DEPTH-1)) ? '0 : wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= (rp_q == AW'(DEPTH-1)) ? '0 : rp_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ===== src/swf_axil.sv
// AXI4-Lite slave front end, one write and one read at a time
`timescale 1ns/1ps
module swf_axil
  import swf_pkg::*;
(
  input  wire logic                      i_mclk,    // Clock
  input  wire logic                      i_nrst,    // Async reset, active low
  input  wire logic [SWF_AXI_ADDR_W-1:0] i_awaddr,  // Write address
  input  wire logic                      i_awvalid, // Write address valid
  output logic                           o_awready, // Write address ready
  input  wire logic [31:0]               i_wdata,   // Write data
  input  wire logic [3:0]                i_wstrb,   // Byte enables
  input  wire logic                      i_wvalid,  // Write data valid
  output logic                           o_wready,  // Write data ready
  output logic [1:0]                     o_bresp,   // Write response
  output logic                           o_bvalid,  // Write response valid
  input  wire logic                      i_bready,  // Write response ready
  input  wire logic [SWF_AXI_ADDR_W-1:0] i_araddr,  // Read address
  input  wire logic                      i_arvalid, // Read address valid
  output logic                           o_arready, // Read address ready
  output logic [31:0]                    o_rdata,   // Read data
  output logic [1:0]                     o_rresp,   // Read response
  output logic                           o_rvalid,  // Read data valid
  input  wire logic                      i_rready,  // Read data ready
  swf_reg_if.bus                         rb         // Register access
);
  logic [11:0] aw_idx_q;
  logic [31:0] wd_q;
  logic [3:0]  ws_q;
  logic        aw_got_q, w_got_q;
  logic        aw_hs, w_hs, aw_have, w_have, do_wr, bv_d, awg_d, wg_d, ar_hs;

  assign aw_hs   = i_awvalid & o_awready;
  assign w_hs    = i_wvalid & o_wready;
  assign aw_have = aw_got_q | aw_hs;
  assign w_have  = w_got_q | w_hs;
  assign do_wr   = aw_have & w_have;
  assign bv_d    = do_wr | (o_bvalid & ~i_bready);
  assign awg_d   = aw_have & ~do_wr;
  assign wg_d    = w_have & ~do_wr;
  assign ar_hs   = i_arvalid & o_arready;

  assign rb.wr_en   = do_wr;
  assign rb.wr_idx  = aw_hs ? swf_idx(i_awaddr) : aw_idx_q;
  assign rb.wr_data = w_hs ? i_wdata : wd_q;
  assign rb.wr_strb = w_hs ? i_wstrb : ws_q;
  assign rb.rd_idx  = swf_idx(i_araddr);

  // Address and data may arrive in either order; each is held until both are here
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      aw_got_q  <= 1'b0;
      w_got_q   <= 1'b0;
      aw_idx_q  <= '0;
      wd_q      <= '0;
      ws_q      <= '0;
      o_awready <= 1'b1;
      o_wready  <= 1'b1;
      o_bvalid  <= 1'b0;
      o_bresp   <= SWF_RESP_OKAY;
    end else begin
      aw_got_q  <= awg_d;
      w_got_q   <= wg_d;
      o_bvalid  <= bv_d;
      o_awready <= ~awg_d & ~bv_d;
      o_wready  <= ~wg_d & ~bv_d;
      if (aw_hs) begin
        aw_idx_q <= swf_idx(i_awaddr);
      end
      if (w_hs) begin
        wd_q <= i_wdata;
        ws_q <= i_wstrb;
      end
      if (do_wr) begin
        o_bresp <= rb.wr_ok ? SWF_RESP_OKAY : SWF_RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_arready <= 1'b1;
      o_rvalid  <= 1'b0;
      o_rdata   <= '0;
      o_rresp   <= SWF_RESP_OKAY;
    end else if (ar_hs) begin
      o_arready <= 1'b0;
      o_rvalid  <= 1'b1;
      o_rdata   <= rb.rd_ok ? rb.rd_data : '0;
      o_rresp   <= rb.rd_ok ? SWF_RESP_OKAY : SWF_RESP_SLVERR;
    end else if (o_rvalid && i_rready) begin
      o_arready <= 1'b1;
      o_rvalid  <= 1'b0;
    end
  end
endmodule

// ===== src/swf_formatter.sv
// Sample word formatter: packs converter samples and digital bits, multiplexes channels
`timescale 1ns/1ps
module swf_formatter
  import swf_pkg::*;
#(
  parameter logic [31:0] FULL_SCALE = SWF_FS_DEFAULT,
  parameter int          FIFO_DEPTH = SWF_FIFO_DEPTH
) (
  input  wire logic                         i_mclk,         // Sample clock
  input  wire logic                         i_nrst,         // Async reset, active low
  input  wire logic [SWF_NCH*SWF_ADC_W-1:0] i_adc_data,     // Channel n at bits 16n+15..16n
  input  wire logic [SWF_NCH*SWF_DIG_PER_CH-1:0] i_dig_chan, // Digital bits, four per channel
  input  wire logic [SWF_REPL_W-1:0]        i_dig_repl,     // Digital inputs for replace mode
  input  wire logic                         i_sample_valid, // One sample of every channel
  output logic                              o_sample_ready, // Idle, next sample set taken unless every channel is disabled
  output swf_word_t                         o_word,         // Buffer word
  output logic                              o_word_valid,   // Word valid
  input  wire logic                         i_word_ready,   // Buffer side accepts
  input  wire logic [SWF_AXI_ADDR_W-1:0]    i_awaddr,       // AXI write address
  input  wire logic                         i_awvalid,      // AXI write address valid
  output logic                              o_awready,      // AXI write address ready
  input  wire logic [31:0]                  i_wdata,        // AXI write data
  input  wire logic [3:0]                   i_wstrb,        // AXI byte enables
  input  wire logic                         i_wvalid,       // AXI write data valid
  output logic                              o_wready,       // AXI write data ready
  output logic [1:0]                        o_bresp,        // AXI write response
  output logic                              o_bvalid,       // AXI write response valid
  input  wire logic                         i_bready,       // AXI write response ready
  input  wire logic [SWF_AXI_ADDR_W-1:0]    i_araddr,       // AXI read address
  input  wire logic                         i_arvalid,      // AXI read address valid
  output logic                              o_arready,      // AXI read address ready
  output logic [31:0]                       o_rdata,        // AXI read data
  output logic [1:0]                        o_rresp,        // AXI read response
  output logic                              o_rvalid,       // AXI read data valid
  input  wire logic                         i_rready        // AXI read data ready
);
  import swf_pkg::*;

  typedef enum logic {
    S_IDLE,
    S_EMIT
  } swf_state_e;

  swf_reg_if                  rb ();
  swf_stream_if #(SWF_ADC_W)  push ();
  swf_stream_if #(SWF_ADC_W)  pop ();

  // Configuration
  logic [SWF_NCH-1:0]  en_q;
  swf_mode_e           mode_q;
  logic [2:0]          rch_q;
  logic                grp_q;
  logic                ovr_q;
  logic                drop_q;

  // Captured sample set
  logic [SWF_NCH*SWF_ADC_W-1:0]      adc_q;
  logic [SWF_NCH*SWF_DIG_PER_CH-1:0] dig_q;
  logic [SWF_REPL_W-1:0]             rep_q;
  logic [SWF_NCH-1:0]                sen_q;
  swf_mode_e                         smode_q;
  logic [2:0]                        srch_q;
  logic                              sgrp_q;

  swf_state_e state_q;
  logic [2:0] slot_q;
  logic       act_a, act_b, both, last_slot, advance;
  logic       cur_mod;
  logic [1:0] cur_rank;
  logic [2:0] pick;
  logic       cur_valid;
  logic [2:0] cur_ch;
  swf_word_t  cur_word;
  logic       take;
  logic [31:0] fs_code;
  logic [31:0] ctrl_rd;
  logic [31:0] stat_rd;

  // Rank r enabled channel within a four channel module: {found, index}
  function automatic logic [2:0] swf_nth(input logic [3:0] m, input logic [1:0] r);
    logic [2:0] res;
    logic [2:0] seen;
    res  = '0;
    seen = '0;
    for (int i = 0; i < SWF_MOD_CH; i++) begin
      if (m[i] && !res[2]) begin
        if (seen[1:0] == r) begin
          res = {1'b1, 2'(i)};
        end
        seen = seen + 3'h1;
      end
    end
    return res;
  endfunction

  // Packs one channel's word according to the digital mode
  function automatic swf_word_t swf_pack(input swf_word_t adc, input logic [3:0] dig,
                                         input swf_mode_e md, input logic is_rep,
                                         input logic grp, input logic [SWF_REPL_W-1:0] rep);
    swf_word_t w;
    case (md)
      digital_capture_off: begin
        w = adc;
      end
      four_digital_bits_in_word: begin
        w = {dig, adc[SWF_ADC_W-1:SWF_FOUR_SHIFT]};
      end
      two_digital_bits_in_word: begin
        w = {dig[1:0], adc[SWF_ADC_W-1:SWF_TWO_SHIFT]};
      end
      digital_replaces_channel: begin
        if (is_rep) begin
          w = grp ? rep[SWF_REPL_W-1:SWF_ADC_W] : rep[SWF_ADC_W-1:0];
        end else begin
          w = adc;
        end
      end
      default: begin
        w = adc;
      end
    endcase
    return w;
  endfunction

  swf_axil u_axil (
    .i_mclk    (i_mclk),
    .i_nrst    (i_nrst),
    .i_awaddr  (i_awaddr),
    .i_awvalid (i_awvalid),
    .o_awready (o_awready),
    .i_wdata   (i_wdata),
    .i_wstrb   (i_wstrb),
    .i_wvalid  (i_wvalid),
    .o_wready  (o_wready),
    .o_bresp   (o_bresp),
    .o_bvalid  (o_bvalid),
    .i_bready  (i_bready),
    .i_araddr  (i_araddr),
    .i_arvalid (i_arvalid),
    .o_arready (o_arready),
    .o_rdata   (o_rdata),
    .o_rresp   (o_rresp),
    .o_rvalid  (o_rvalid),
    .i_rready  (i_rready),
    .rb        (rb.bus)
  );

  swf_fifo #(
    .W     (SWF_ADC_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_mclk (i_mclk),
    .i_nrst (i_nrst),
    .wr     (push.snk),
    .rd     (pop.src)
  );

  // fewer converter bits in the word scale the full-scale code down
  always_comb begin
    case (mode_q)
      four_digital_bits_in_word: fs_code = FULL_SCALE >> SWF_FOUR_SHIFT;
      two_digital_bits_in_word:  fs_code = FULL_SCALE >> SWF_TWO_SHIFT;
      default:                   fs_code = FULL_SCALE;
    endcase
  end

  always_comb begin
    ctrl_rd = '0;
    ctrl_rd[SWF_EN_LSB +: SWF_NCH] = en_q;
    ctrl_rd[SWF_MODE_LSB +: 2]     = mode_q;
    ctrl_rd[SWF_RCH_LSB +: 3]      = rch_q;
    ctrl_rd[SWF_GRP_BIT]           = grp_q;
    stat_rd = '0;
    stat_rd[SWF_OVR_BIT]  = ovr_q;
    stat_rd[SWF_BUSY_BIT] = (state_q == S_EMIT);
    stat_rd[SWF_DROP_BIT] = drop_q;
  end

  always_comb begin
    rb.rd_ok   = 1'b1;
    rb.rd_data = '0;
    case (rb.rd_idx)
      SWF_CTRL_IDX:   rb.rd_data = ctrl_rd;
      SWF_STAT_IDX:   rb.rd_data = stat_rd;
      SWF_FSCODE_IDX: rb.rd_data = fs_code;
      default:        rb.rd_ok   = 1'b0;
    endcase
  end

  // The full-scale code is read-only, so a write there is refused
  assign rb.wr_ok = (rb.wr_idx == SWF_CTRL_IDX) || (rb.wr_idx == SWF_STAT_IDX);

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      en_q   <= SWF_CTRL_RST[SWF_EN_LSB +: SWF_NCH];
      mode_q <= digital_capture_off;
      rch_q  <= '0;
      grp_q  <= 1'b0;
    end else if (rb.wr_en && rb.wr_idx == SWF_CTRL_IDX) begin
      if (rb.wr_strb[0]) begin
        en_q <= rb.wr_data[SWF_EN_LSB +: SWF_NCH];
      end
      if (rb.wr_strb[1]) begin
        mode_q <= swf_mode_e'(rb.wr_data[SWF_MODE_LSB +: 2]);
        rch_q  <= rb.wr_data[SWF_RCH_LSB +: 3];
        grp_q  <= rb.wr_data[SWF_GRP_BIT];
      end
    end
  end

  // Sample sets that arrive while busy are lost; set beats a clearing write
  assign take = i_sample_valid && (state_q == S_IDLE) && (en_q != '0);

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      ovr_q  <= 1'b0;
      drop_q <= 1'b0;
    end else begin
      if (i_sample_valid && state_q == S_EMIT) begin
        ovr_q <= 1'b1;
      end else if (rb.wr_en && rb.wr_idx == SWF_STAT_IDX && rb.wr_strb[0] && rb.wr_data[SWF_OVR_BIT]) begin
        ovr_q <= 1'b0;
      end
      if (i_sample_valid && state_q == S_IDLE && en_q == '0) begin
        drop_q <= 1'b1;
      end else if (rb.wr_en && rb.wr_idx == SWF_STAT_IDX && rb.wr_strb[0] && rb.wr_data[SWF_DROP_BIT]) begin
        drop_q <= 1'b0;
      end
    end
  end

  // Configuration is frozen per sample set so a word never mixes two settings
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      adc_q   <= '0;
      dig_q   <= '0;
      rep_q   <= '0;
      sen_q   <= '0;
      smode_q <= digital_capture_off;
      srch_q  <= '0;
      sgrp_q  <= 1'b0;
    end else if (take) begin
      adc_q   <= i_adc_data;
      dig_q   <= i_dig_chan;
      rep_q   <= i_dig_repl;
      sen_q   <= en_q;
      smode_q <= mode_q;
      srch_q  <= rch_q;
      sgrp_q  <= grp_q;
    end
  end

  // low four channels form the first module
  assign act_a = (sen_q[SWF_MOD_CH-1:0] != '0);
  assign act_b = (sen_q[SWF_NCH-1:SWF_MOD_CH] != '0);
  assign both  = act_a & act_b;

  always_comb begin
    // even slots first module, odd slots second, rank advances per pair
    if (both) begin
      cur_mod  = slot_q[0];
      cur_rank = slot_q[2:1];
    // single module walks its channels upward
    end else begin
      cur_mod  = act_b;
      cur_rank = slot_q[1:0];
    end
    pick      = swf_nth(cur_mod ? sen_q[SWF_NCH-1:SWF_MOD_CH] : sen_q[SWF_MOD_CH-1:0], cur_rank);
    cur_valid = pick[2];
    cur_ch    = {cur_mod, pick[1:0]};
  end

  // word packed from the selected channel's 16-bit sample and digital bits, or from i_dig_repl per mode
  assign cur_word = swf_pack(adc_q[cur_ch*SWF_ADC_W +: SWF_ADC_W],
                             dig_q[cur_ch*SWF_DIG_PER_CH +: SWF_DIG_PER_CH],
                             smode_q, (cur_ch == srch_q), sgrp_q, rep_q);

  assign push.valid = (state_q == S_EMIT) && cur_valid;
  assign push.data  = cur_word;
  // A full FIFO stalls the walk; empty slots are skipped in one cycle
  assign advance    = ~cur_valid | push.ready;
  assign last_slot  = both ? (slot_q == 3'h7) : (slot_q == 3'h3);

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_q        <= S_IDLE;
      slot_q         <= '0;
      o_sample_ready <= 1'b1;
    end else begin
      case (state_q)
        S_IDLE: begin
          slot_q <= '0;
          if (take) begin
            state_q        <= S_EMIT;
            o_sample_ready <= 1'b0;
          end
        end
        S_EMIT: begin
          if (advance) begin
            slot_q <= slot_q + 3'h1;
            if (last_slot) begin
              state_q        <= S_IDLE;
              o_sample_ready <= 1'b1;
            end
          end
        end
        default: begin
          state_q        <= S_IDLE;
          o_sample_ready <= 1'b1;
        end
      endcase
    end
  end

  // Output stage keeps the buffer port straight off flip-flops
  assign pop.ready = ~o_word_valid | i_word_ready;

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_word       <= '0;
      o_word_valid <= 1'b0;
    end else if (pop.ready) begin
      o_word_valid <= pop.valid;
      if (pop.valid) begin
        o_word <= pop.data;
      end
    end
  end
endmodule

// ===== tb/swf_sink.sv
// Buffer-side word sink: prompt, slow or stopped acceptance
`timescale 1ns/1ps
module swf_sink
  import swf_pkg::*;
(
  input  wire logic      i_mclk,  // Clock
  input  wire logic      i_nrst,  // Async reset, active low
  input  wire logic      i_valid, // Word offered
  input  swf_word_t      i_word,  // Offered word
  input  wire logic[1:0] i_stall, // 0 prompt, 1 one in four, 2 stopped
  output logic           o_ready  // Word accepted at this edge
);
  swf_word_t got[$];
  logic [1:0] ph_q;
  // raw words kept, bench masks and sign-extends
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_ready <= 1'b0;
      ph_q    <= 2'h0;
    end else begin
      if (i_valid && o_ready) got.push_back(i_word);
      ph_q    <= ph_q + 2'h1;
      o_ready <= (i_stall == 2'h0) || (i_stall == 2'h1 && ph_q == 2'h3);
    end
  end
endmodule

// ===== tb/swf_sva.sv
// Port assertions of the sample word formatter
`timescale 1ns/1ps
module swf_sva
  import swf_pkg::*;
(
  input wire logic i_mclk, i_nrst, i_sample_valid, o_sample_ready, o_word_valid, i_word_ready,
  input swf_word_t o_word,
  input wire logic [SWF_AXI_ADDR_W-1:0] i_awaddr, i_araddr,
  input wire logic i_awvalid, o_awready, i_wvalid, o_wready, o_bvalid, i_arvalid, o_arready, o_rvalid, i_rready,
  input wire logic [1:0] o_bresp,
  input wire logic [31:0] o_rdata
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);
  // A set offered with every channel masked is refused, so take is confirmed by ready dropping
  sequence s_take; i_sample_valid && o_sample_ready ##1 !o_sample_ready; endsequence
  sequence s_wr; i_awvalid && o_awready && i_wvalid && o_wready; endsequence
  sequence s_rd; i_arvalid && o_arready; endsequence
  property p_word_hold; o_word_valid && !i_word_ready |=> o_word_valid && $stable(o_word); endproperty
  a_word_hold: assert property (p_word_hold) else $error("word changed while stalled");
  property p_walk; s_take |=> !o_sample_ready [*3]; endproperty
  a_walk: assert property (p_walk) else $error("sample set walk too short");
  property p_ready_back; $fell(o_sample_ready) |-> ##[1:300] o_sample_ready; endproperty
  a_ready_back: assert property (p_ready_back) else $error("sample ready never returned");
  property p_word_out; s_take |-> ##[1:6] o_word_valid; endproperty
  a_word_out: assert property (p_word_out) else $error("no word after sample set");
  property p_fs_wr; s_wr ##0 (i_awaddr[13:2] == SWF_FSCODE_IDX) |=> o_bvalid && o_bresp == SWF_RESP_SLVERR; endproperty
  a_fs_wr: assert property (p_fs_wr) else $error("full-scale write not refused");
  property p_fs_rd; s_rd ##0 (i_araddr[13:2] == SWF_FSCODE_IDX) |=> o_rdata != 0 && o_rdata <= SWF_FS_DEFAULT; endproperty
  a_fs_rd: assert property (p_fs_rd) else $error("full-scale code out of range");
  property p_rd; s_rd |=> o_rvalid && !o_arready; endproperty
  a_rd: assert property (p_rd) else $error("read answer late");
  property p_rhold; o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata); endproperty
  a_rhold: assert property (p_rhold) else $error("read data dropped");
endmodule
bind swf_formatter swf_sva u_sva (.i_mclk, .i_nrst, .i_sample_valid, .o_sample_ready, .o_word_valid, .i_word_ready,
  .o_word, .i_awaddr, .i_araddr, .i_awvalid, .o_awready, .i_wvalid, .o_wready, .o_bvalid, .i_arvalid, .o_arready,
  .o_rvalid, .i_rready, .o_bresp, .o_rdata);

// ===== tb/swf_formatter_tb.sv
// Self-checking bench of the sample word formatter
`timescale 1ns/1ps
module swf_formatter_tb;
  import swf_pkg::*;
  logic i_mclk = 0, i_nrst = 0, i_sample_valid = 0, i_awvalid = 0, i_wvalid = 0, i_bready = 0, i_arvalid = 0;
  logic i_rready = 0, o_sample_ready, o_word_valid, wrdy, o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic [127:0] i_adc_data = 0;
  logic [31:0]  i_dig_chan = 0, i_dig_repl = 32'hc3a5_5a3c, i_wdata = 0, o_rdata, d;
  logic [13:0]  i_awaddr = 0, i_araddr = 0;
  logic [3:0]   i_wstrb = 4'hf;
  logic [1:0]   o_bresp, o_rresp, r, stall = 0;
  swf_word_t    o_word, g;
  swf_word_t    expq[$];
  int           fails = 0, cmp_count = 0;
  initial forever #10 i_mclk = ~i_mclk;
  swf_formatter dut (.i_mclk, .i_nrst, .i_adc_data, .i_dig_chan, .i_dig_repl, .i_sample_valid, .o_sample_ready,
    .o_word, .o_word_valid, .i_word_ready(wrdy), .i_awaddr, .i_awvalid, .o_awready, .i_wdata, .i_wstrb, .i_wvalid,
    .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid,
    .i_rready);
  swf_sink sink (.i_mclk, .i_nrst, .i_valid(o_word_valid), .i_word(o_word), .i_stall(stall), .o_ready(wrdy));
  task automatic check(input string n, input logic [31:0] e, input logic [31:0] s);
    cmp_count++;
    if (s !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic close_out;
    if (fails == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic axw(input logic [13:0] a, input logic [31:0] v, output logic [1:0] rs);
    @(posedge i_mclk);
    {i_awaddr, i_wdata, i_awvalid, i_wvalid, i_bready} <= {a, v, 3'b111};
    fork
      begin #1; while (o_awready !== 1) begin @(posedge i_mclk); #1; end @(posedge i_mclk); i_awvalid <= 0; end
      begin #1; while (o_wready !== 1) begin @(posedge i_mclk); #1; end @(posedge i_mclk); i_wvalid <= 0; end
    join
    #1; while (o_bvalid !== 1) begin @(posedge i_mclk); #1; end
    rs = o_bresp;
    @(posedge i_mclk);
    i_bready <= 0;
  endtask
  task automatic axr(input logic [13:0] a, output logic [31:0] q, output logic [1:0] rs);
    @(posedge i_mclk);
    {i_araddr, i_arvalid, i_rready} <= {a, 2'b11};
    #1; while (o_arready !== 1) begin @(posedge i_mclk); #1; end
    @(posedge i_mclk);
    i_arvalid <= 0;
    #1; while (o_rvalid !== 1) begin @(posedge i_mclk); #1; end
    {q, rs} = {o_rdata, o_rresp};
    @(posedge i_mclk);
    i_rready <= 0;
  endtask
  function automatic swf_word_t aval(int c, int k);
    return 16'(c * 16'h2345 + k * 16'h00f1 + 16'h8001);
  endfunction
  function automatic logic [3:0] dval(int c, int k);
    return 4'(c + k * 5);
  endfunction
  function automatic swf_word_t wexp(int c, int k, logic [31:0] t);
    swf_word_t a;
    logic [3:0] dv;
    a = aval(c, k);
    dv = dval(c, k);
    case (t[9:8])
      2'h1: return {dv, a[15:4]};
      2'h2: return {dv[1:0], a[15:2]};
      2'h3: if (c == t[14:12]) return t[15] ? i_dig_repl[31:16] : i_dig_repl[15:0];
      default: ;
    endcase
    return a;
  endfunction
  task automatic run(input logic [31:0] t, input int n);
    int o;
    sink.got.delete();
    expq.delete();
    axw(14'h0000, t, r);
    for (int k = 0; k < n; k++) begin
      // A set offered while busy would count as an overrun, so wait for ready first
      #1; while (o_sample_ready !== 1) begin @(posedge i_mclk); #1; end
      @(posedge i_mclk);
      for (int c = 0; c < 8; c++) {i_adc_data[16*c+:16], i_dig_chan[4*c+:4]} <= {aval(c, k), dval(c, k)};
      i_sample_valid <= 1;
      @(posedge i_mclk);
      i_sample_valid <= 0;
      if (t[3:0] != 0 && t[7:4] != 0)
        for (int q = 0; q < 8; q++) begin
          o = 0;
          for (int j = 0; j < 4; j++) if (t[4*q[0]+j]) begin if (o == q / 2) expq.push_back(wexp(4*q[0]+j, k, t)); o++; end
        end
      else
        for (int c = 0; c < 8; c++) if (t[c]) expq.push_back(wexp(c, k, t));
    end
    while (sink.got.size() < expq.size()) @(posedge i_mclk);
    repeat (4) @(posedge i_mclk);
    check("word count", expq.size(), sink.got.size());
    foreach (expq[i]) check("word", expq[i], sink.got[i]);
  endtask
  initial begin
    #400us;
    fails++;
    close_out();
  end
  initial begin
    repeat (3) @(posedge i_mclk);
    i_nrst <= 1;
    axr(14'h1198, d, r);
    check("full scale", 32'h8000, d);
    axw(14'h1198, 32'h1, r);
    check("full scale write", SWF_RESP_SLVERR, r);
    axr(14'h2000, d, r);
    check("unmapped read", SWF_RESP_SLVERR, r);
    run(32'h01, 3);
    stall <= 1;
    run(32'h11, 2);
    stall <= 0;
    run(32'h0c, 2);
    stall <= 2;
    fork
      run(32'hff, 2);
      begin repeat (40) @(posedge i_mclk); #1; check("full buffer", 0, o_sample_ready); stall <= 0; end
    join
    run(32'h103, 2);
    axr(14'h1198, d, r);
    check("full scale four", 32'h800, d);
    run(32'h101, 1);
    g = sink.got[0];
    check("signed field", 32'($signed(aval(0, 0)) >>> 4), 32'($signed(g[11:0])));
    run(32'h202, 2);
    axr(14'h1198, d, r);
    check("full scale two", 32'h2000, d);
    run(32'h1312, 1);
    run(32'h9312, 1);
    close_out();
  end
endmodule
